// ---- logic/dbg_break_pkg.sv ----
// Constants shared by the break and branch trace logic.
// Assumes a 32-bit CPU address/data bus observed once per clock by the core.
//
// Summary of operation
// RL1 - Three independent break channels request a halt.
// RL2 - Address matches bus address or program counter.
// RL3 - Data match qualified by byte, word, longword size.
// RL4 - Direction compares read/write indicator with selection.
// RL5 - Bus type: CPU all, CPU data, miss/DMA.
// RL6 - Internal I/O access raises a break.
// RL7 - Count holds off break until N satisfactions.
// RL8 - Channel 1: address, data, bus-state, count.
// RL9 - Channel 2: address and bus-state only.
// RL10 - Channel 3: internal I/O access only.
// RL11 - Debugger picks bus type by memory space.
// RL12 - Trace keeps source/destination of four branches.
// RL13 - Trace is branch-only; no other records.
// RL14 - Skip zero-displacement conditionals and reset branch.
// RL15 - Debugger uses CPU bus type for counts.
// RL16 - Halt may land two or more instructions late.
// RL17 - Trace store overwrites oldest entry circularly.
package dbg_break_pkg;
  localparam int ADDR_W = 32;                           // Bus address width
  localparam int DATA_W = 32;                           // Bus data width
  localparam int CNT_W = 16;                            // Occurrence counter width
  localparam int TRACE_DEPTH = 4;                       // Branches retained
  localparam int TRACE_PTR_W = 2;                       // Trace index width
  localparam int HALT_DELAY = 2;                        // Instructions before the halt lands
  localparam logic [1:0] SIZE_BYTE = 2'h0;              // Access size codes
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] BUS_CPU_ALL = 2'h0;            // Bus type choices
  localparam logic [1:0] BUS_CPU_DATA = 2'h1;
  localparam logic [1:0] BUS_MISS_DMA = 2'h2;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'hA0000000; // Branch target on reset
endpackage

// ---- logic/break_channel.sv ----
// One address/data/bus-state/count break channel.
// Assumes bus observation signals are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module break_channel #(
  parameter bit HAS_DATA  = 1'b1,                       // Data compare present
  parameter bit HAS_COUNT = 1'b1                        // Occurrence counter present
) (
  input  wire logic                                  core_clk,     // Core clock
  input  wire logic                                  reset_n,      // Async reset, active low
  input  wire logic                                  enable,       // Channel armed
  input  wire logic                                  use_addr,     // Address condition on
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      cmp_addr,     // Compare address
  input  wire logic                                  use_data,     // Data condition on
  input  wire logic [dbg_break_pkg::DATA_W-1:0]      cmp_data,     // Compare data
  input  wire logic [1:0]                            cmp_size,     // Compare access size
  input  wire logic                                  use_dir,      // Direction condition on
  input  wire logic                                  cmp_read,     // 1 selects reads
  input  wire logic                                  use_bus,      // Bus type condition on
  input  wire logic [1:0]                            cmp_bus,      // Selected bus type
  input  wire logic [dbg_break_pkg::CNT_W-1:0]       cmp_count,    // Required occurrences
  input  wire logic                                  bus_valid,    // Bus cycle this clock
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      bus_addr,     // Bus address
  input  wire logic [dbg_break_pkg::DATA_W-1:0]      bus_data,     // Bus data
  input  wire logic [1:0]                            bus_size,     // Bus access size
  input  wire logic                                  read_write_indicator, // 1 on read
  input  wire logic                                  bus_fetch,    // Cycle is a fetch
  input  wire logic                                  bus_cache_hit,// Cycle hit the cache
  input  wire logic                                  bus_dma,      // Cycle from the DMA
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      pc,           // Program counter
  input  wire logic                                  pc_valid,     // PC stage valid
  output logic                                       hit           // One-cycle match pulse
);
  typedef struct packed {
    logic [dbg_break_pkg::CNT_W-1:0] count;             // Occurrences so far
    logic                            hit;               // Registered hit
  } ch_state_type;
  ch_state_type state_reg;
  ch_state_type state_next;
  logic match;                                          // Conditions met this cycle

  // Compare data lanes only as wide as the access
  function automatic logic data_eq(input logic [31:0] a, input logic [31:0] b, input logic [1:0] sz);
    case (sz)
      dbg_break_pkg::SIZE_BYTE: data_eq = (a[7:0] == b[7:0]);
      dbg_break_pkg::SIZE_WORD: data_eq = (a[15:0] == b[15:0]);
      default:                  data_eq = (a == b);
    endcase
  endfunction

  // Bus type decode; miss/DMA takes CPU cache misses or DMA data cycles
  function automatic logic bus_eq(input logic [1:0] sel, input logic fetch, input logic chit, input logic dma);
    case (sel)
      dbg_break_pkg::BUS_CPU_ALL:  bus_eq = !dma;                          // RL5
      dbg_break_pkg::BUS_CPU_DATA: bus_eq = !dma && !fetch;                // RL5
      dbg_break_pkg::BUS_MISS_DMA: bus_eq = dma ? !fetch : !chit;          // RL5
      default:                     bus_eq = 1'b0;
    endcase
  endfunction

  // Combine enabled conditions; a channel with nothing enabled never matches
  always_comb begin
    state_next = state_reg;
    match = enable && (use_addr || (HAS_DATA && use_data) || use_dir || use_bus);
    if (use_addr) begin
      match = match && ((bus_valid && bus_addr == cmp_addr) || (pc_valid && pc == cmp_addr)); // RL2
    end
    if (HAS_DATA && use_data) begin
      match = match && bus_valid && bus_size == cmp_size && data_eq(bus_data, cmp_data, cmp_size); // RL3
    end
    if (use_dir) begin
      match = match && bus_valid && (read_write_indicator == cmp_read); // RL4
    end
    if (use_bus) begin
      match = match && bus_valid && bus_eq(cmp_bus, bus_fetch, bus_cache_hit, bus_dma); // RL5
    end
    state_next.hit = 1'b0;
    if (!enable) begin
      state_next.count = '0;                            // Disarm restarts the count
    end else if (match) begin
      if (HAS_COUNT && cmp_count > 16'h0001 && state_reg.count + 16'h0001 < cmp_count) begin
        state_next.count = state_reg.count + 16'h0001;  // RL7
      end else begin
        state_next.count = '0;
        state_next.hit = 1'b1;                          // RL7
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hit = state_reg.hit;

  a_hit_needs_enable: assert property (@(posedge core_clk) disable iff (!reset_n)
    hit |-> $past(enable)) else $error("hit without enable"); // RL7
endmodule
`default_nettype wire

// ---- logic/break_trace.sv ----
// Three break channels and a four-entry branch trace store.
// Assumes CPU bus, PC and branch retire signals are on core_clk; the
// debugger's settings are held steady while the channels are armed.
`timescale 1ns/100ps
`default_nettype none
module break_trace (
  input  wire logic                                  core_clk,        // Core clock
  input  wire logic                                  reset_n,         // Async reset, active low
  // Channel 1 settings
  input  wire logic                                  ch1_enable,      // Arm channel 1
  input  wire logic                                  ch1_use_addr,    // Address condition
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      ch1_addr,        // Compare address
  input  wire logic                                  ch1_use_data,    // Data condition
  input  wire logic [dbg_break_pkg::DATA_W-1:0]      ch1_data,        // Compare data
  input  wire logic [1:0]                            ch1_size,        // Compare size
  input  wire logic                                  ch1_use_dir,     // Direction condition
  input  wire logic                                  ch1_read,        // 1 selects reads
  input  wire logic                                  ch1_use_bus,     // Bus type condition
  input  wire logic [1:0]                            ch1_bus,         // Bus type
  input  wire logic [dbg_break_pkg::CNT_W-1:0]       ch1_count,       // Occurrences to break
  // Channel 2 settings
  input  wire logic                                  ch2_enable,      // Arm channel 2
  input  wire logic                                  ch2_use_addr,    // Address condition
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      ch2_addr,        // Compare address
  input  wire logic                                  ch2_use_dir,     // Direction condition
  input  wire logic                                  ch2_read,        // 1 selects reads
  input  wire logic                                  ch2_use_bus,     // Bus type condition
  input  wire logic [1:0]                            ch2_bus,         // Bus type
  // Channel 3 settings
  input  wire logic                                  ch3_enable,      // Arm internal I/O break
  // Observed CPU activity
  input  wire logic                                  bus_valid,       // Bus cycle this clock
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      bus_addr,        // Bus address
  input  wire logic [dbg_break_pkg::DATA_W-1:0]      bus_data,        // Bus data
  input  wire logic [1:0]                            bus_size,        // Access size
  input  wire logic                                  read_write_indicator, // 1 on read
  input  wire logic                                  bus_fetch,       // Instruction fetch
  input  wire logic                                  bus_cache_hit,   // Cache hit
  input  wire logic                                  bus_dma,         // DMA-originated
  input  wire logic                                  bus_int_io,      // Internal I/O access
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      pc,              // Program counter
  input  wire logic                                  pc_valid,        // PC valid
  input  wire logic                                  insn_retire,     // Instruction completed
  // Branch retire
  input  wire logic                                  branch_taken,    // Branch completed
  input  wire logic                                  branch_cond,     // Conditional true/false branch
  input  wire logic                                  branch_disp_zero,// Displacement was zero
  input  wire logic                                  branch_reset,    // Branch caused by reset
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      branch_src,      // Source address
  input  wire logic [dbg_break_pkg::ADDR_W-1:0]      branch_dst,      // Destination address
  input  wire logic                                  trace_enable,    // Record branches
  input  wire logic [dbg_break_pkg::TRACE_PTR_W-1:0] trace_sel,       // 0 newest .. 3 oldest
  input  wire logic                                  break_clear,     // Debugger resumes
  // Results
  output logic                                       halt_req,        // Halt request level
  output logic [2:0]                                 break_cause,     // Sticky channel hits
  output logic [dbg_break_pkg::ADDR_W-1:0]           trace_src,       // Selected source
  output logic [dbg_break_pkg::ADDR_W-1:0]           trace_dst,       // Selected destination
  output logic                                       trace_valid,     // Selected entry valid
  output logic [2:0]                                 trace_fill       // Entries held, 0..4
);
  localparam int N = dbg_break_pkg::TRACE_DEPTH;

  typedef struct packed {
    logic [N-1:0][dbg_break_pkg::ADDR_W-1:0] src;       // Source ring
    logic [N-1:0][dbg_break_pkg::ADDR_W-1:0] dst;       // Destination ring
    logic [dbg_break_pkg::TRACE_PTR_W-1:0]   wptr;      // Next slot to write
    logic [2:0]                              fill;      // Valid entries
    logic [2:0]                              cause;     // Sticky hits
    logic                                    pending;   // Hit awaiting halt
    logic [1:0]                              lag;       // Instructions since hit
    logic                                    halt;      // Halt request
    logic [dbg_break_pkg::ADDR_W-1:0]        out_src;   // Registered readout
    logic [dbg_break_pkg::ADDR_W-1:0]        out_dst;
    logic                                    out_valid;
  } top_state_type;
  top_state_type state_reg;
  top_state_type state_next;
  logic [1:0] hits;                                     // Channel 1 and 2 pulses
  logic       record;                                   // Branch to store
  logic [dbg_break_pkg::TRACE_PTR_W-1:0] rd_idx;        // Selected slot

  // Channel 1: full set, no internal I/O
  break_channel #(.HAS_DATA(1'b1), .HAS_COUNT(1'b1)) u_ch1 ( // RL8
    .core_clk(core_clk), .reset_n(reset_n), .enable(ch1_enable),
    .use_addr(ch1_use_addr), .cmp_addr(ch1_addr), .use_data(ch1_use_data), .cmp_data(ch1_data),
    .cmp_size(ch1_size), .use_dir(ch1_use_dir), .cmp_read(ch1_read), .use_bus(ch1_use_bus),
    .cmp_bus(ch1_bus), .cmp_count(ch1_count), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_data(bus_data), .bus_size(bus_size), .read_write_indicator(read_write_indicator),
    .bus_fetch(bus_fetch), .bus_cache_hit(bus_cache_hit), .bus_dma(bus_dma), .pc(pc),
    .pc_valid(pc_valid), .hit(hits[0]));

  // Channel 2: address and bus state; data and count tied off by structure
  break_channel #(.HAS_DATA(1'b0), .HAS_COUNT(1'b0)) u_ch2 ( // RL9
    .core_clk(core_clk), .reset_n(reset_n), .enable(ch2_enable),
    .use_addr(ch2_use_addr), .cmp_addr(ch2_addr), .use_data(1'b0), .cmp_data(32'h00000000),
    .cmp_size(dbg_break_pkg::SIZE_LONG), .use_dir(ch2_use_dir), .cmp_read(ch2_read),
    .use_bus(ch2_use_bus), .cmp_bus(ch2_bus), .cmp_count(16'h0000), .bus_valid(bus_valid),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_size(bus_size),
    .read_write_indicator(read_write_indicator), .bus_fetch(bus_fetch),
    .bus_cache_hit(bus_cache_hit), .bus_dma(bus_dma), .pc(pc), .pc_valid(pc_valid), .hit(hits[1]));

  // Only branches the trace keeps; no other record kinds exist here
  assign record = trace_enable && branch_taken && !(branch_cond && branch_disp_zero)
                  && !(branch_reset && branch_dst == dbg_break_pkg::RESET_VECTOR); // RL14 RL13
  assign rd_idx = state_reg.wptr - 2'h1 - trace_sel;    // Newest is one behind the write slot

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // Channel 3: any internal I/O access, no other qualifier
    state_next.cause = state_reg.cause | {1'b0, hits};  // RL1
    if (ch3_enable && bus_valid && bus_int_io) begin
      state_next.cause[2] = 1'b1;                       // RL6 RL10
    end
    // A hit at the clearing edge survives the clear
    if (break_clear) begin
      state_next.cause = {ch3_enable && bus_valid && bus_int_io, hits};
      state_next.halt = 1'b0;
      state_next.pending = 1'b0;
      state_next.lag = 2'h0;
    end
    if (state_next.cause != 3'h0 && !state_reg.halt && !state_reg.pending && !break_clear) begin
      state_next.pending = 1'b1;                        // RL1
    end
    if (state_reg.pending && !break_clear) begin
      // Let the pipeline drain; halt lands after the delay count of instructions
      if (insn_retire) begin
        state_next.lag = state_reg.lag + 2'h1;          // RL16
      end
      if (state_reg.lag == 2'(dbg_break_pkg::HALT_DELAY)) begin
        state_next.halt = 1'b1;                         // RL16
        state_next.pending = 1'b0;
        state_next.lag = 2'h0;
      end
    end
    if (break_clear && state_next.cause != 3'h0) begin
      state_next.pending = 1'b1;
    end
    // Circular store overwrites the oldest slot
    if (record) begin
      state_next.src[state_reg.wptr] = branch_src;      // RL12
      state_next.dst[state_reg.wptr] = branch_dst;      // RL12
      state_next.wptr = state_reg.wptr + 2'h1;          // RL17
      if (state_reg.fill != 3'(N)) begin
        state_next.fill = state_reg.fill + 3'h1;        // RL17
      end
    end
    state_next.out_src = state_reg.src[rd_idx];
    state_next.out_dst = state_reg.dst[rd_idx];
    state_next.out_valid = {1'b0, trace_sel} < state_reg.fill;
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign halt_req = state_reg.halt;
  assign break_cause = state_reg.cause;
  assign trace_src = state_reg.out_src;
  assign trace_dst = state_reg.out_dst;
  assign trace_valid = state_reg.out_valid;
  assign trace_fill = state_reg.fill;

  a_halt_needs_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(halt_req) |-> break_cause != 3'h0) else $error("halt with no cause"); // RL1
  a_halt_not_early: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(halt_req) |-> $past(state_reg.lag) == 2'h2) else $error("halt before two instructions"); // RL16
  a_io_break_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
    ch3_enable && bus_valid && bus_int_io |=> break_cause[2]) else $error("io access missed"); // RL6
  a_io_only_ch3: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(break_cause[2]) |-> $past(ch3_enable && bus_valid && bus_int_io)) else $error("ch3 stray"); // RL10
  a_trace_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    record |=> state_reg.src[$past(state_reg.wptr)] == $past(branch_src)) else $error("trace lost"); // RL12
  a_skip_zero_disp: assert property (@(posedge core_clk) disable iff (!reset_n)
    branch_taken && branch_cond && branch_disp_zero |=> $stable(state_reg.wptr)) else $error("zero disp kept"); // RL14
  a_fill_bounded: assert property (@(posedge core_clk) disable iff (!reset_n)
    trace_fill <= 3'h4) else $error("fill over depth"); // RL17
  a_wrap_ptr: assert property (@(posedge core_clk) disable iff (!reset_n)
    record && state_reg.wptr == 2'h3 |=> state_reg.wptr == 2'h0) else $error("no wrap"); // RL17
endmodule
`default_nettype wire

// ---- bench/dbg_host_model.sv ----
// Debugger model: holds the break channel settings and trace controls.
// Assumes the bench calls its tasks from one process; changes land at a falling edge.
`timescale 1ns/100ps
`default_nettype none
module dbg_host_model (
  input  wire logic        core_clk,     // Core clock
  output logic             ch1_enable,   // Channel 1 armed
  output logic             ch1_use_addr, // Address condition
  output logic [31:0]      ch1_addr,     // Compare address
  output logic             ch1_use_data, // Data condition
  output logic [31:0]      ch1_data,     // Compare data
  output logic [1:0]       ch1_size,     // Compare size
  output logic             ch1_use_dir,  // Direction condition
  output logic             ch1_read,     // 1 selects reads
  output logic             ch1_use_bus,  // Bus type condition
  output logic [1:0]       ch1_bus,      // Bus type
  output logic [15:0]      ch1_count,    // Occurrences to break
  output logic             ch2_enable,   // Channel 2 armed
  output logic             ch2_use_addr, // Address condition
  output logic [31:0]      ch2_addr,     // Compare address
  output logic             ch2_use_dir,  // Direction condition
  output logic             ch2_read,     // 1 selects reads
  output logic             ch2_use_bus,  // Bus type condition
  output logic [1:0]       ch2_bus,      // Bus type
  output logic             ch3_enable,   // Internal I/O break armed
  output logic             trace_enable, // Record branches
  output logic [1:0]       trace_sel,    // Trace entry picked
  output logic             break_clear   // Resume pulse
);
  // Everything idle at time zero; tracing stays on for the whole run
  initial begin
    {ch1_enable, ch1_use_addr, ch1_use_data, ch1_use_dir, ch1_read, ch1_use_bus, ch1_addr, ch1_data} = '0;
    {ch1_size, ch1_bus, ch1_count, ch2_enable, ch2_use_addr, ch2_addr, ch2_use_dir, ch2_read} = '0;
    {ch2_use_bus, ch2_bus, ch3_enable, trace_sel, break_clear} = '0;
    trace_enable = 1'b1;
  end
  // Rearm channel 1; flags are {enable, addr, data, dir, read, bus}
  task automatic arm1(input logic [5:0] f, input logic [31:0] a, d, input logic [1:0] sz, bs, input logic [15:0] n);
    @(negedge core_clk);
    {ch1_enable, ch1_use_addr, ch1_use_data, ch1_use_dir, ch1_read, ch1_use_bus} = f;
    {ch1_addr, ch1_data, ch1_size, ch1_count} = {a, d, sz, n};
    // Miss/DMA type misbehaves with counts, so the debugger never pairs them
    ch1_bus = (n > 16'h1 && bs == dbg_break_pkg::BUS_MISS_DMA) ? dbg_break_pkg::BUS_CPU_DATA : bs;
  endtask
  // Rearm channel 2; the caller picks the bus type by memory space, flags {enable, addr, dir, read, bus}
  task automatic arm2(input logic [4:0] f, input logic [31:0] a, input logic [1:0] bs);
    @(negedge core_clk);
    {ch2_enable, ch2_use_addr, ch2_use_dir, ch2_read, ch2_use_bus, ch2_addr, ch2_bus} = {f, a, bs};
  endtask
  // Arm or disarm the internal I/O channel
  task automatic arm3(input logic e);
    @(negedge core_clk);
    ch3_enable = e;
  endtask
  // Pick a trace entry for readout
  task automatic pick(input logic [1:0] s);
    @(negedge core_clk);
    trace_sel = s;
  endtask
  // One-cycle resume pulse
  task automatic clr();
    @(negedge core_clk);
    break_clear = 1'b1;
    @(negedge core_clk);
    break_clear = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the break channels and branch trace store.
// Assumes the debugger model owns the settings; the bench plays the core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;                // 100 MHz core clock
  logic reset_n = 1'b0;                 // Reset, active low
  logic bus_valid = 0, read_write_indicator = 0, bus_fetch = 0, bus_cache_hit = 0, bus_dma = 0, bus_int_io = 0;
  logic pc_valid = 0, insn_retire = 0, branch_taken = 0, branch_cond = 0, branch_disp_zero = 0, branch_reset = 0;
  logic [31:0] bus_addr = '0, bus_data = '0, pc = '0, branch_src = '0, branch_dst = '0;
  logic [1:0] bus_size = '0;            // Access size
  wire logic ch1_enable, ch1_use_addr, ch1_use_data, ch1_use_dir, ch1_read, ch1_use_bus, ch2_enable;
  wire logic ch2_use_addr, ch2_use_dir, ch2_read, ch2_use_bus, ch3_enable, trace_enable, break_clear;
  wire logic [31:0] ch1_addr, ch1_data, ch2_addr, trace_src, trace_dst;
  wire logic [1:0] ch1_size, ch1_bus, ch2_bus, trace_sel;
  wire logic [15:0] ch1_count;          // Occurrence count
  wire logic halt_req, trace_valid;     // Results
  wire logic [2:0] break_cause, trace_fill;
  int num_errors = 0, total_checks = 0; // Tallies
  // Bus type table: reject cycle {fetch, hit} then accept cycle, per type
  logic [1:0] bus_types [3] = '{dbg_break_pkg::BUS_CPU_ALL, dbg_break_pkg::BUS_CPU_DATA, dbg_break_pkg::BUS_MISS_DMA};
  localparam logic [2:0] BAD_F = 3'h2, BAD_H = 3'h6, GOOD_F = 3'h1, GOOD_H = 3'h3;
  always #5 core_clk = ~core_clk;
  dbg_host_model i_dbg_host_model (.*);
  break_trace i_break_trace (.*);
  // Compare and tally
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait on a cause bit, or the halt request for index 3
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 12; i++) begin
      @(negedge core_clk);
      if (((w == 3) ? halt_req : break_cause[w]) === 1'b1) break;
    end
    if (i == 12) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // One bus cycle; valid drops after so stale values cannot match later
  task automatic cyc(input logic [31:0] a, d, input logic [1:0] sz, input logic rd, f, h, io);
    @(negedge core_clk);
    {bus_valid, bus_addr, bus_data, bus_size, read_write_indicator, bus_fetch, bus_cache_hit, bus_int_io} = {1'b1, a, d, sz, rd, f, h, io};
    @(negedge core_clk);
    {bus_valid, bus_int_io, bus_dma} = 3'h0;
  endtask
  // One program counter observation
  task automatic pcs(input logic [31:0] a);
    @(negedge core_clk);
    {pc_valid, pc} = {1'b1, a};
    @(negedge core_clk);
    pc_valid = 1'b0;
  endtask
  // One retired branch
  task automatic br(input logic [31:0] s, d, input logic c, z, r);
    @(negedge core_clk);
    {branch_taken, branch_src, branch_dst, branch_cond, branch_disp_zero, branch_reset} = {1'b1, s, d, c, z, r};
    @(negedge core_clk);
    branch_taken = 1'b0;
  endtask
  // One retired instruction
  task automatic retire();
    @(negedge core_clk);
    insn_retire = 1'b1;
    @(negedge core_clk);
    insn_retire = 1'b0;
  endtask
  // Hang guard well above the length of the run
  initial begin
    #100us;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    check("reset cause", break_cause, 3'h0);
    // Internal I/O break and a halt that trails by two instructions
    i_dbg_host_model.arm3(1'b1);
    cyc(32'h0, 32'h0, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1);
    wait_for(2);
    check("io cause", break_cause, 3'h4);
    retire();
    check("early halt", halt_req, 1'h0);
    retire();
    wait_for(3);
    check("halt", halt_req, 1'h1);
    i_dbg_host_model.arm3(1'b0);
    i_dbg_host_model.clr();
    check("cleared", {halt_req, break_cause}, 4'h0);
    $display("io break test done");
    // Address count of three through bus and PC; channel 1 ignores I/O
    i_dbg_host_model.arm1(6'h30, 32'h1000, 32'h0, 2'h0, 2'h0, 16'h3);
    cyc(32'h0, 32'h0, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1);
    pcs(32'h1000);
    cyc(32'h1000, 32'h0, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) @(negedge core_clk);
    check("count hold", break_cause, 3'h0);
    pcs(32'h1000);
    wait_for(0);
    check("count cause", break_cause, 3'h1);
    i_dbg_host_model.clr();
    $display("count test done");
    // Data byte compare with read direction: wrong size, wrong direction, then a match
    i_dbg_host_model.arm1(6'h2E, 32'h0, 32'hA5, dbg_break_pkg::SIZE_BYTE, 2'h0, 16'h0);
    cyc(32'h0, 32'hA5, dbg_break_pkg::SIZE_WORD, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(32'h0, 32'hA5, dbg_break_pkg::SIZE_BYTE, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (4) @(negedge core_clk);
    check("data reject", break_cause, 3'h0);
    cyc(32'h0, 32'hA5, dbg_break_pkg::SIZE_BYTE, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_for(0);
    check("data cause", break_cause, 3'h1);
    i_dbg_host_model.arm1(6'h0, 32'h0, 32'h0, 2'h0, 2'h0, 16'h0);
    i_dbg_host_model.clr();
    $display("data test done");
    // Channel 2 address break under each bus type
    for (int k = 0; k < 3; k++) begin
      i_dbg_host_model.arm2(5'h19, 32'h2000, bus_types[k]);
      bus_dma = (k == 0);
      cyc(32'h2000, 32'h0, 2'h2, 1'b1, BAD_F[k], BAD_H[k], 1'b0);
      repeat (4) @(negedge core_clk);
      check("bus reject", break_cause, 3'h0);
      cyc(32'h2000, 32'h0, 2'h2, 1'b1, GOOD_F[k], GOOD_H[k], 1'b0);
      wait_for(1);
      check("bus accept", break_cause, 3'h2);
      i_dbg_host_model.clr();
    end
    $display("bus type test done");
    // Five branches plus two skipped ones; only the last four remain
    for (int k = 1; k <= 5; k++) begin
      br(32'h100 * k, 32'h200 * k, 1'b0, 1'b0, 1'b0);
      if (k == 3) br(32'h3333, 32'h3336, 1'b1, 1'b1, 1'b0);
      if (k == 4) br(32'h4444, dbg_break_pkg::RESET_VECTOR, 1'b0, 1'b0, 1'b1);
    end
    repeat (2) @(negedge core_clk);
    check("fill", trace_fill, 3'h4);
    for (int s = 0; s < 4; s++) begin
      i_dbg_host_model.pick(s[1:0]);
      repeat (2) @(negedge core_clk);
      check("trace src", trace_src, 32'h100 * (5 - s));
      check("trace dst", trace_dst, 32'h200 * (5 - s));
      check("trace valid", trace_valid, 1'b1);
    end
    $display("trace test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
